//--- verilog/ospc_top.sv
// Overview of operation
// - after power-up completes, enter Standby with no host action
// - each state except radio-active and radio-idle drives a fixed oscillator, radio and logic supply set
// - every entry into Standby sends the standby-entered event
// - Standby runs on crystal, radio off, halted until a command
// - Sleep never enables the radio and is only left towards Standby
// - UART Sleep: wake pin high restarts clocks, enters Standby with event
// - SPI Sleep: limited commands, radio-enabling commands refused
// - SPI Sleep: set-state to Standby moves to Standby, other targets refused
// - Deep-Sleep: radio off, interface only wakes, default wake to Standby
// - UART Deep-Sleep: wake pin high restarts clocks, Standby with event
// - SPI Deep-Sleep: commands other than set-state to Standby or Deep-Sleep wake into Sleep and are attempted
// - set-state from Deep-Sleep: Standby with event, silent Deep-Sleep, or Sleep with reply
// - radio-active is entered only from Standby or radio-idle
// - radio-active runs on crystal, interface open, radio switched dynamically
// - only the device moves between radio-active and radio-idle
// - radio-idle defaults to crystal; other modes need power-mode config
// - UART idle is crystal only; SPI may use RC or external timer
// - radio-idle keeps radio off and accepts any command except set-state, which is refused
`timescale 1ns/1ps
`default_nettype none

module ospc_top #(
   parameter logic HAS_EXT_TIMER = 1'h0
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // pins
   input wire logic wake_pin,
   input wire logic iface_sel,
   // start-up sequencer
   input wire logic powerup_done,
   // decoded host commands
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire ospc_pkg::ospc_cmd_s cmd,
   // events to host
   output logic evt_valid,
   output ospc_pkg::ospc_evt_s evt,
   // link layer
   input wire logic link_radio_req,
   input wire logic link_idle_req,
   input wire logic link_wake_req,
   input wire logic link_done,
   // power and status
   output ospc_pkg::ospc_pwr_s pwr,
   output ospc_pkg::ospc_state_e op_state,
   output logic core_halt
);

   // ----------------------------------------------------------------
   // reset and pin synchronisers
   // ----------------------------------------------------------------
   logic rst_n;
   logic [1:0] pins;
   logic wake;
   logic spi;

   ospc_sync #(.W(1)) u_rst_sync (
      .clk(clk),
      .rst_n(reset_n),
      .din(1'h1),
      .q(rst_n)
   );

   ospc_sync #(.W(2)) u_pin_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din({wake_pin, iface_sel}),
      .q(pins)
   );

   assign wake = (pins[1] == ospc_pkg::WAKE_ACTIVE);
   assign spi = (pins[0] == ospc_pkg::SEL_SPI);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   ospc_pkg::ospc_state_s s;
   ospc_pkg::ospc_state_s n;
   ospc_pkg::ospc_pwr_s next_pwr;
   ospc_pkg::ospc_idle_e idle_eff;
   ospc_pkg::ospc_status_e stat;
   logic take;
   logic reply;
   logic sb_evt;
   logic link_busy;
   logic radio_cmd;
   logic set_cmd;

   assign radio_cmd = (cmd.op == ospc_pkg::cmd_radio_start);
   assign set_cmd = (cmd.op == ospc_pkg::cmd_set_state);

   // idle mode actually usable on the chosen transport
   always_comb begin
      idle_eff = ospc_pkg::idle_xtal;
      if (spi && (s.idle_cfg == ospc_pkg::idle_rc)) begin
         idle_eff = ospc_pkg::idle_rc;
      end else if (spi && HAS_EXT_TIMER && (s.idle_cfg == ospc_pkg::idle_ext)) begin
         idle_eff = ospc_pkg::idle_ext;
      end
   end

   // link layer state changes take the cycle, commands wait
   assign link_busy = link_done || (s.st == ospc_pkg::ospc_active && link_idle_req) ||
                      (s.st == ospc_pkg::ospc_idle && link_wake_req);
   assign cmd_ready = (s.st != ospc_pkg::ospc_boot) && !(link_busy &&
                      (s.st == ospc_pkg::ospc_active || s.st == ospc_pkg::ospc_idle));
   assign take = cmd_valid && cmd_ready;

   ospc_pwr_map u_pwr_map (
      .st(n.st),
      .idle_eff(idle_eff),
      .radio_req(link_radio_req),
      .pwr(next_pwr)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      n = s;
      n.evt_valid = 1'h0;
      reply = 1'h0;
      sb_evt = 1'h0;
      stat = ospc_pkg::status_ok;
      case (s.st)
         ospc_pkg::ospc_boot: begin
            if (powerup_done) begin
               n.st = ospc_pkg::ospc_standby;
               sb_evt = 1'h1;
            end
         end
         ospc_pkg::ospc_standby: begin
            if (take) begin
               reply = 1'h1;
               if (radio_cmd) begin
                  n.st = ospc_pkg::ospc_active;
               end else if (set_cmd && cmd.target == ospc_pkg::tgt_sleep) begin
                  n.st = ospc_pkg::ospc_sleep;
               end else if (set_cmd && cmd.target == ospc_pkg::tgt_deep) begin
                  n.st = ospc_pkg::ospc_deep;
               end else if (cmd.op == ospc_pkg::cmd_power_cfg) begin
                  n.idle_cfg = cmd.idle;
               end
            end
         end
         ospc_pkg::ospc_sleep: begin
            if (!spi) begin
               if (wake) begin
                  n.st = ospc_pkg::ospc_standby;
                  sb_evt = 1'h1;
               end
            end else if (take) begin
               reply = 1'h1;
               if (set_cmd && cmd.target == ospc_pkg::tgt_standby) begin
                  n.st = ospc_pkg::ospc_standby;
                  sb_evt = 1'h1;
               end else if (radio_cmd || set_cmd) begin
                  stat = ospc_pkg::status_refused;
               end else if (cmd.op == ospc_pkg::cmd_power_cfg) begin
                  n.idle_cfg = cmd.idle;
               end
            end
         end
         ospc_pkg::ospc_deep: begin
            if (!spi) begin
               if (wake) begin
                  n.st = ospc_pkg::ospc_standby;
                  sb_evt = 1'h1;
               end
            end else if (take) begin
               if (set_cmd && cmd.target == ospc_pkg::tgt_standby) begin
                  n.st = ospc_pkg::ospc_standby;
                  sb_evt = 1'h1;
               end else if (set_cmd && cmd.target == ospc_pkg::tgt_deep) begin
                  n.st = ospc_pkg::ospc_deep;
               end else begin
                  n.st = ospc_pkg::ospc_sleep;
                  reply = 1'h1;
                  if (radio_cmd) begin
                     stat = ospc_pkg::status_refused;
                  end else if (cmd.op == ospc_pkg::cmd_power_cfg) begin
                     n.idle_cfg = cmd.idle;
                  end
               end
            end
         end
         ospc_pkg::ospc_active, ospc_pkg::ospc_idle: begin
            if (link_done) begin
               n.st = ospc_pkg::ospc_standby;
               sb_evt = 1'h1;
            end else if (s.st == ospc_pkg::ospc_active && link_idle_req) begin
               n.st = ospc_pkg::ospc_idle;
            end else if (s.st == ospc_pkg::ospc_idle && link_wake_req) begin
               n.st = ospc_pkg::ospc_active;
            end else if (take) begin
               reply = 1'h1;
               if (set_cmd) begin
                  stat = ospc_pkg::status_refused;
               end else if (cmd.op == ospc_pkg::cmd_power_cfg) begin
                  n.idle_cfg = cmd.idle;
               end
            end
         end
         default: begin
            n.st = ospc_pkg::ospc_boot;
         end
      endcase
      if (sb_evt) begin
         n.evt_valid = 1'h1;
         n.evt = '{ospc_pkg::evt_standby_entered, ospc_pkg::status_ok};
      end else if (reply) begin
         n.evt_valid = 1'h1;
         n.evt = '{ospc_pkg::evt_cmd_complete, stat};
      end
      n.pwr = next_pwr;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= ospc_pkg::STATE_RESET;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign evt_valid = s.evt_valid;
   assign evt = s.evt;
   assign pwr = s.pwr;
   assign op_state = s.st;
   assign core_halt = (s.st == ospc_pkg::ospc_standby) && !cmd_valid;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence in_low_power;
      (s.st == ospc_pkg::ospc_sleep || s.st == ospc_pkg::ospc_deep);
   endsequence

   sequence standby_with_event;
      s.st == ospc_pkg::ospc_standby && s.evt_valid && s.evt.kind == ospc_pkg::evt_standby_entered;
   endsequence

   boot_to_standby_a: assert property (
      s.st == ospc_pkg::ospc_boot && powerup_done |=> standby_with_event)
      else $error("boot did not reach standby");

   deep_config_a: assert property (
      s.st == ospc_pkg::ospc_deep |-> !s.pwr.xtal_on && !s.pwr.rc_on && s.pwr.vlogic_high == ospc_pkg::VLOGIC_1V4)
      else $error("deep sleep power set wrong");

   standby_event_a: assert property (
      s.st != ospc_pkg::ospc_standby ##1 s.st == ospc_pkg::ospc_standby |-> standby_with_event)
      else $error("standby entered without event");

   sleep_exit_a: assert property (
      s.st == ospc_pkg::ospc_sleep |-> !s.pwr.radio_on ##1 (s.st inside {ospc_pkg::ospc_sleep, ospc_pkg::ospc_standby}))
      else $error("sleep left wrongly");

   uart_wake_a: assert property (
      in_low_power ##0 (!spi && wake) |=> standby_with_event ##0 s.pwr.xtal_on)
      else $error("wake pin ignored");

   sleep_refuse_a: assert property (
      s.st == ospc_pkg::ospc_sleep && spi && take && radio_cmd |=>
      s.st == ospc_pkg::ospc_sleep && s.evt_valid && s.evt.status == ospc_pkg::status_refused)
      else $error("radio command not refused in sleep");

   deep_silent_a: assert property (
      s.st == ospc_pkg::ospc_deep && spi && take && set_cmd && cmd.target == ospc_pkg::tgt_deep |=>
      s.st == ospc_pkg::ospc_deep && !s.evt_valid)
      else $error("deep sleep return not silent");

   deep_to_sleep_a: assert property (
      s.st == ospc_pkg::ospc_deep && spi && take && !set_cmd |=> s.st == ospc_pkg::ospc_sleep && s.evt_valid)
      else $error("deep sleep command did not wake to sleep");

   active_entry_a: assert property (
      !(s.st inside {ospc_pkg::ospc_standby, ospc_pkg::ospc_active, ospc_pkg::ospc_idle}) |=>
      s.st != ospc_pkg::ospc_active)
      else $error("active entered from wrong state");

   uart_idle_a: assert property (
      s.st == ospc_pkg::ospc_idle && !spi && $stable(spi) |-> s.pwr.xtal_on && !s.pwr.radio_on)
      else $error("uart idle left crystal");

   refuse_hold_a: assert property (
      s.st == ospc_pkg::ospc_active && take && set_cmd |=>
      s.st == ospc_pkg::ospc_active && s.evt_valid && s.evt.status == ospc_pkg::status_refused ##1
      (!s.evt_valid || $past(take) || $past(link_done)))
      else $error("refused command changed state");

endmodule

`default_nettype wire

//--- inc/ospc_pkg.sv
package ospc_pkg;

   // ----------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {ospc_boot, ospc_deep, ospc_sleep, ospc_standby, ospc_active, ospc_idle} ospc_state_e;
   typedef enum logic [2:0] {cmd_generic, cmd_radio_start, cmd_radio_stop, cmd_set_state, cmd_power_cfg} ospc_op_e;
   typedef enum logic [1:0] {tgt_standby, tgt_sleep, tgt_deep} ospc_target_e;
   typedef enum logic [1:0] {idle_xtal, idle_rc, idle_ext} ospc_idle_e;
   typedef enum logic [1:0] {pm_quiescent, pm_xtreme, pm_standby} ospc_pmode_e;
   typedef enum logic {evt_standby_entered, evt_cmd_complete} ospc_evt_e;
   typedef enum logic {status_ok, status_refused} ospc_status_e;

   // ----------------------------------------------------------------
   // supply levels and pin levels
   // ----------------------------------------------------------------
   localparam logic VLOGIC_1V8 = 1'h1;
   localparam logic VLOGIC_1V4 = 1'h0;
   localparam logic SEL_SPI = 1'h1;
   localparam logic WAKE_ACTIVE = 1'h1;
   localparam int SYNC_STAGES = 2;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      ospc_op_e op;
      ospc_target_e target;
      ospc_idle_e idle;
   } ospc_cmd_s;

   typedef struct packed {
      ospc_evt_e kind;
      ospc_status_e status;
   } ospc_evt_s;

   typedef struct packed {
      ospc_pmode_e mode;
      logic xtal_on;
      logic rc_on;
      logic radio_on;
      logic vlogic_high;
   } ospc_pwr_s;

   typedef struct packed {
      ospc_state_e st;
      ospc_idle_e idle_cfg;
      logic evt_valid;
      ospc_evt_s evt;
      ospc_pwr_s pwr;
   } ospc_state_s;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam ospc_idle_e IDLE_CFG_RESET = idle_xtal;
   localparam ospc_pwr_s PWR_RESET = '{mode: pm_xtreme, xtal_on: 1'h0, rc_on: 1'h1, radio_on: 1'h0,
                                       vlogic_high: VLOGIC_1V8};
   localparam ospc_evt_s EVT_RESET = '{kind: evt_cmd_complete, status: status_ok};
   localparam ospc_state_s STATE_RESET = '{st: ospc_boot, idle_cfg: IDLE_CFG_RESET, evt_valid: 1'h0,
                                           evt: EVT_RESET, pwr: PWR_RESET};

endpackage

//--- verilog/ospc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ospc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // data
   input wire logic [W-1:0] din,
   output logic [W-1:0] q
);

   // ----------------------------------------------------------------
   // two flop chain
   // ----------------------------------------------------------------
   logic [ospc_pkg::SYNC_STAGES-1:0][W-1:0] chain;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chain <= '0;
      end else begin
         chain <= {chain[0], din};
      end
   end

   assign q = chain[ospc_pkg::SYNC_STAGES-1];

endmodule

`default_nettype wire

//--- verilog/ospc_pwr_map.sv
`timescale 1ns/1ps
`default_nettype none

module ospc_pwr_map (
   // state
   input wire ospc_pkg::ospc_state_e st,
   input wire ospc_pkg::ospc_idle_e idle_eff,
   input wire logic radio_req,
   // power configuration
   output ospc_pkg::ospc_pwr_s pwr
);

   // ----------------------------------------------------------------
   // state to power mode table
   // ----------------------------------------------------------------
   always_comb begin
      pwr = ospc_pkg::PWR_RESET;
      case (st)
         ospc_pkg::ospc_deep: begin
            pwr = '{ospc_pkg::pm_quiescent, 1'h0, 1'h0, 1'h0, ospc_pkg::VLOGIC_1V4};
         end
         ospc_pkg::ospc_sleep: begin
            pwr = '{ospc_pkg::pm_xtreme, 1'h0, 1'h1, 1'h0, ospc_pkg::VLOGIC_1V4};
         end
         ospc_pkg::ospc_standby: begin
            pwr = '{ospc_pkg::pm_standby, 1'h1, 1'h1, 1'h0, ospc_pkg::VLOGIC_1V8};
         end
         ospc_pkg::ospc_active: begin
            pwr = '{ospc_pkg::pm_standby, 1'h1, 1'h1, radio_req, ospc_pkg::VLOGIC_1V8};
         end
         ospc_pkg::ospc_idle: begin
            case (idle_eff)
               ospc_pkg::idle_rc: begin
                  pwr = '{ospc_pkg::pm_xtreme, 1'h0, 1'h1, 1'h0, ospc_pkg::VLOGIC_1V8};
               end
               ospc_pkg::idle_ext: begin
                  pwr = '{ospc_pkg::pm_quiescent, 1'h0, 1'h0, 1'h0, ospc_pkg::VLOGIC_1V4};
               end
               default: begin
                  pwr = '{ospc_pkg::pm_standby, 1'h1, 1'h1, 1'h0, ospc_pkg::VLOGIC_1V8};
               end
            endcase
         end
         default: begin
            pwr = ospc_pkg::PWR_RESET;
         end
      endcase
   end

endmodule

`default_nettype wire

//--- dv/ospc_host.sv
`timescale 1ns/1ps
`default_nettype none

module ospc_host (
   // clock
   input wire logic clk,
   // command bus
   input wire logic cmd_ready,
   output logic cmd_valid,
   output ospc_pkg::ospc_cmd_s cmd,
   // events and state
   input wire logic evt_valid,
   input wire ospc_pkg::ospc_evt_s evt,
   input wire ospc_pkg::ospc_state_e op_state,
   // pins
   output logic wake_pin,
   output logic iface_sel
);
   int evt_cnt;
   ospc_pkg::ospc_evt_s last_evt;

   initial begin
      cmd_valid = 1'h0;
      cmd = '0;
      wake_pin = ~ospc_pkg::WAKE_ACTIVE;
      iface_sel = ospc_pkg::SEL_SPI;
      evt_cnt = 0;
      last_evt = '0;
   end

   // ----------------------------------------------------------------
   // event capture
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (evt_valid === 1'h1) begin
         evt_cnt <= evt_cnt + 1;
         last_evt <= evt;
      end
   end

   // ----------------------------------------------------------------
   // host actions, entered just after a rising edge
   // ----------------------------------------------------------------
   task automatic send(input ospc_pkg::ospc_op_e o, input ospc_pkg::ospc_target_e t, input ospc_pkg::ospc_idle_e i);
      logic ok;
      int n;
      if (iface_sel != ospc_pkg::SEL_SPI && op_state inside {ospc_pkg::ospc_sleep, ospc_pkg::ospc_deep}) begin
         return;
      end
      ok = 1'h0;
      n = 0;
      cmd_valid = 1'h1;
      cmd = '{op: o, target: t, idle: i};
      while (!ok && n < 20) begin
         @(negedge clk);
         ok = (cmd_ready === 1'h1);
         n++;
         @(posedge clk);
      end
      #2;
      cmd_valid = 1'h0;
      cmd = ~cmd;
   endtask

   task automatic wake();
      wake_pin = ospc_pkg::WAKE_ACTIVE;
      repeat (6) @(posedge clk);
      #2;
      wake_pin = ~ospc_pkg::WAKE_ACTIVE;
   endtask

   task automatic select(input logic s);
      iface_sel = s;
      repeat (4) @(posedge clk);
      #2;
   endtask
endmodule

`default_nettype wire

//--- dv/ospc_top_test.sv
`timescale 1ns/1ps
`default_nettype none

module ospc_top_test;
   logic clk, reset_n, powerup_done, cmd_valid, cmd_ready, evt_valid, wake_pin, iface_sel, core_halt;
   logic link_radio_req, link_idle_req, link_wake_req, link_done;
   ospc_pkg::ospc_cmd_s cmd;
   ospc_pkg::ospc_evt_s evt;
   ospc_pkg::ospc_pwr_s pwr;
   ospc_pkg::ospc_state_e op_state;
   int mismatches, samples_checked, seen;
   // power sets: mode then xtal, rc, radio, 1.8V
   localparam ospc_pkg::ospc_pwr_s p_stby = {ospc_pkg::pm_standby, 4'hd};
   localparam ospc_pkg::ospc_pwr_s p_act = {ospc_pkg::pm_standby, 4'hf};
   localparam ospc_pkg::ospc_pwr_s p_slp = {ospc_pkg::pm_xtreme, 4'h4};
   localparam ospc_pkg::ospc_pwr_s p_rc = {ospc_pkg::pm_xtreme, 4'h5};
   localparam ospc_pkg::ospc_pwr_s p_deep = {ospc_pkg::pm_quiescent, 4'h0};

   ospc_top u_ospc_top (.clk(clk), .reset_n(reset_n), .wake_pin(wake_pin), .iface_sel(iface_sel),
      .powerup_done(powerup_done), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
      .evt_valid(evt_valid), .evt(evt), .link_radio_req(link_radio_req), .link_idle_req(link_idle_req),
      .link_wake_req(link_wake_req), .link_done(link_done), .pwr(pwr), .op_state(op_state),
      .core_halt(core_halt));

   ospc_host u_ospc_host (.clk(clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd(cmd),
      .evt_valid(evt_valid), .evt(evt), .op_state(op_state), .wake_pin(wake_pin), .iface_sel(iface_sel));

   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // e: 0 no event, 1 standby entered, 2 complete ok, 3 complete refused
   task automatic look(input string w, input ospc_pkg::ospc_state_e s, input ospc_pkg::ospc_pwr_s p, input int e);
      logic [1:0] ev;
      ev = (e == 1) ? 2'h0 : (e == 2) ? 2'h2 : 2'h3;
      cyc(2);
      chk({w, " state"}, 8'(s), 8'(op_state));
      chk({w, " power"}, 8'(p), 8'(pwr));
      chk({w, " events"}, 8'(e != 0), 8'(u_ospc_host.evt_cnt - seen));
      if (e != 0) chk({w, " event"}, 8'(ev), 8'(u_ospc_host.last_evt));
      seen = u_ospc_host.evt_cnt;
   endtask

   task automatic ss(input ospc_pkg::ospc_target_e t);
      u_ospc_host.send(ospc_pkg::cmd_set_state, t, ospc_pkg::idle_xtal);
   endtask

   task automatic op(input ospc_pkg::ospc_op_e o, input ospc_pkg::ospc_idle_e i);
      u_ospc_host.send(o, ospc_pkg::tgt_standby, i);
   endtask

   task automatic pulse_done();
      link_done = 1'h1;
      cyc(1);
      link_done = 1'h0;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_boot();
      chk("boot state", 8'(ospc_pkg::ospc_boot), 8'(op_state));
      chk("boot ready", 8'h00, 8'(cmd_ready));
      powerup_done = 1'h1;
      look("boot", ospc_pkg::ospc_standby, p_stby, 1);
      chk("halt", 8'h01, 8'(core_halt));
      $display("test boot done");
   endtask

   task automatic t_active();
      op(ospc_pkg::cmd_radio_start, ospc_pkg::idle_xtal);
      look("start", ospc_pkg::ospc_active, p_stby, 2);
      link_radio_req = 1'h1;
      look("radio", ospc_pkg::ospc_active, p_act, 0);
      ss(ospc_pkg::tgt_standby);
      look("force", ospc_pkg::ospc_active, p_act, 3);
      link_radio_req = 1'h0;
      link_idle_req = 1'h1;
      look("to idle", ospc_pkg::ospc_idle, p_stby, 0);
      link_idle_req = 1'h0;
      op(ospc_pkg::cmd_generic, ospc_pkg::idle_xtal);
      look("idle cmd", ospc_pkg::ospc_idle, p_stby, 2);
      link_wake_req = 1'h1;
      look("to active", ospc_pkg::ospc_active, p_stby, 0);
      link_wake_req = 1'h0;
      pulse_done();
      look("done", ospc_pkg::ospc_standby, p_stby, 1);
      $display("test active done");
   endtask

   task automatic t_sleep();
      ss(ospc_pkg::tgt_sleep);
      look("sleep", ospc_pkg::ospc_sleep, p_slp, 2);
      op(ospc_pkg::cmd_radio_start, ospc_pkg::idle_xtal);
      look("sleep radio", ospc_pkg::ospc_sleep, p_slp, 3);
      ss(ospc_pkg::tgt_deep);
      look("sleep deep", ospc_pkg::ospc_sleep, p_slp, 3);
      ss(ospc_pkg::tgt_standby);
      look("sleep exit", ospc_pkg::ospc_standby, p_stby, 1);
      $display("test sleep done");
   endtask

   task automatic t_deep();
      ss(ospc_pkg::tgt_deep);
      look("deep", ospc_pkg::ospc_deep, p_deep, 2);
      ss(ospc_pkg::tgt_deep);
      look("deep stay", ospc_pkg::ospc_deep, p_deep, 0);
      ss(ospc_pkg::tgt_standby);
      look("deep exit", ospc_pkg::ospc_standby, p_stby, 1);
      ss(ospc_pkg::tgt_deep);
      look("deep again", ospc_pkg::ospc_deep, p_deep, 2);
      op(ospc_pkg::cmd_radio_start, ospc_pkg::idle_xtal);
      look("deep radio", ospc_pkg::ospc_sleep, p_slp, 3);
      ss(ospc_pkg::tgt_standby);
      look("deep back", ospc_pkg::ospc_standby, p_stby, 1);
      $display("test deep done");
   endtask

   task automatic t_uart();
      u_ospc_host.select(~ospc_pkg::SEL_SPI);
      ss(ospc_pkg::tgt_sleep);
      look("u sleep", ospc_pkg::ospc_sleep, p_slp, 2);
      u_ospc_host.wake();
      look("u wake", ospc_pkg::ospc_standby, p_stby, 1);
      ss(ospc_pkg::tgt_deep);
      look("u deep", ospc_pkg::ospc_deep, p_deep, 2);
      u_ospc_host.wake();
      look("u deep wake", ospc_pkg::ospc_standby, p_stby, 1);
      $display("test uart done");
   endtask

   task automatic t_idle(input logic s, input ospc_pkg::ospc_idle_e i, input ospc_pkg::ospc_pwr_s p);
      u_ospc_host.select(s);
      op(ospc_pkg::cmd_power_cfg, i);
      look("cfg", ospc_pkg::ospc_standby, p_stby, 2);
      op(ospc_pkg::cmd_radio_start, ospc_pkg::idle_xtal);
      look("cfg start", ospc_pkg::ospc_active, p_stby, 2);
      link_idle_req = 1'h1;
      look("cfg idle", ospc_pkg::ospc_idle, p, 0);
      link_idle_req = 1'h0;
      pulse_done();
      look("cfg done", ospc_pkg::ospc_standby, p_stby, 1);
      $display("test idle done");
   endtask

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #(25 * 3000);
      mismatches++;
      final_report();
   end

   initial begin
      {mismatches, samples_checked, seen} = '0;
      reset_n = 1'h0;
      {powerup_done, link_radio_req, link_idle_req, link_wake_req, link_done} = '0;
      cyc(3);
      reset_n = 1'h1;
      cyc(6);
      t_boot();
      t_active();
      t_sleep();
      t_deep();
      t_idle(ospc_pkg::SEL_SPI, ospc_pkg::idle_rc, p_rc);
      t_idle(ospc_pkg::SEL_SPI, ospc_pkg::idle_ext, p_stby);
      t_uart();
      t_idle(~ospc_pkg::SEL_SPI, ospc_pkg::idle_rc, p_stby);
      final_report();
   end
endmodule

`default_nettype wire
